// >>> bench/ebcs_ctrl_checker.sv
// Purpose: bus control checker
// Assumes: pins pass two sync flops
// Notes: host mode and float need four quiet cycles
`timescale 1ns/1ps
module ebcs_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic bus_mode_select_i,
   input wire logic output_disable_n_i,
   input wire logic acc_busy_o,
   input wire logic acc_done_o,
   input wire logic memory_strobe_n_o,
   input wire logic memory_strobe_oe_o,
   input wire logic rw_o,
   input wire logic rw_oe_o,
   input wire logic ready_oe_o,
   input wire logic io_space_select_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence host_s; !bus_mode_select_i[*4]; endsequence
   sequence held_s; acc_busy_o ##1 acc_busy_o; endsequence
   a_strobe_mode: assert property (
      host_s |-> !memory_strobe_oe_o) else $error("strobe in host");
   a_strobe_off: assert property (
      !output_disable_n_i[*4] |-> !memory_strobe_oe_o) else $error("no float");
   a_ready_dir: assert property (
      bus_mode_select_i[*4] |-> !ready_oe_o) else $error("ready driven");
   a_io_idle: assert property (
      bus_mode_select_i[*4] ##0 !acc_busy_o |-> io_space_select_n_o)
      else $error("io select low when idle");
   a_rw_host: assert property (
      host_s |-> !rw_oe_o) else $error("rw driven in host");
   a_rw_idle: assert property (
      !acc_busy_o |-> rw_o) else $error("rw low when idle");
   a_strobe_idle: assert property (
      !acc_busy_o |-> memory_strobe_n_o) else $error("strobe idle low");
   a_hold_steady: assert property (
      held_s |-> $stable(memory_strobe_n_o) && $stable(rw_o))
      else $error("pins moved in access");
   a_done_end: assert property (
      acc_done_o |-> $past(acc_busy_o) && !acc_busy_o) else $error("bad done");
endmodule
bind ebcs_ctrl ebcs_checker u_chk (.*);

// >>> bench/ebcs_mem_model.sv
// Purpose: external memory that throttles with ready
// Assumes: select low while it is accessed
// Notes: ready low for hold_i cycles of each access
`timescale 1ns/1ps
module ebcs_mem_model (
   input wire logic clk_i,
   input wire logic sel_n_i,
   input wire logic [3:0] hold_i,
   output logic ready_o
);
   logic [3:0] cnt_r = 4'h0;
   assign ready_o = cnt_r >= hold_i;
   // saturate so a long access never drops ready again
   always @(posedge clk_i)
      cnt_r <= sel_n_i ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
endmodule

// >>> bench/tb_ebcs_ctrl.sv
// Purpose: bench for external bus control
// Assumes: model answers ready after hold cycles
// Notes: timing compared fast against slow partner
`timescale 1ns/1ps
module tb_ebcs_ctrl;
   logic clk_i = '0, reset_n_i = '0, bus_mode_select_i = '1, rw_i = '0;
   logic output_disable_n_i = '1, acc_start_i = '0, acc_write_i = '0;
   logic acc_io_i = '0, host_data_ready_i = '1, io_space_select_n_i = '1;
   logic general_io_b_line3_i = '0, general_io_b_line3_dir_i = '0;
   logic timer_b_output_i = '1, timer_b_sel_i = '1, ready_i, mdl_rdy;
   logic [2:0] acc_wait_i = 3'h0;
   logic acc_busy_o, acc_done_o, memory_strobe_n_o, memory_strobe_oe_o;
   logic ready_o, ready_oe_o, rw_o, rw_oe_o, host_rw_o;
   logic io_space_select_n_o, io_space_select_oe_o, general_io_b_line3_o;
   logic [3:0] hold = 4'h0;
   int failures = 0, comparisons = 0, cyc = 0, n, f;
   assign ready_i = ready_oe_o ? ready_o : mdl_rdy;
   ebcs_ctrl u_dut (.*);
   ebcs_mem_model u_mem (.clk_i(clk_i), .ready_o(mdl_rdy), .hold_i(hold),
      .sel_n_i(memory_strobe_n_o & io_space_select_n_o));
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (++cyc == 3000) begin
      failures++;
      results();
   end
   task automatic step(int k = 1);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(logic s, logic e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %0t value mismatch", $time);
      end
   endtask
   task automatic access(logic w, logic io, int ws, logic [3:0] h);
      {acc_write_i, acc_io_i, acc_wait_i, hold} = {w, io, ws[2:0], h};
      acc_start_i = 1'h1;
      step();
      acc_start_i = 1'h0;
      for (n = 1; !acc_done_o && n < 40; n++) begin
         chk(rw_o, !w);
         chk(io ? io_space_select_n_o : memory_strobe_n_o, 1'h0);
         step();
      end
      chk(acc_done_o, 1'h1);
   endtask
   task automatic t_ready();
      for (int ws = 0; ws < 4; ws++) begin
         access(ws[0], 1'h0, ws, 4'h0);
         f = n;
         access(ws[0], ws[1], ws, 4'h6);
         chk(n == f, ws < 2);
         chk(n > f, ws >= 2);
      end
      $display("ready test done");
   endtask
   task automatic t_host();
      bus_mode_select_i = 1'h0;
      step(5);
      chk(ready_o & ready_oe_o, 1'h1);
      chk(host_rw_o, 1'h0);
      chk(io_space_select_n_o & io_space_select_oe_o, 1'h1);
      {timer_b_sel_i, general_io_b_line3_i} = 2'h1;
      step(4);
      chk(general_io_b_line3_o & io_space_select_n_o, 1'h1);
      chk(io_space_select_oe_o, 1'h0);
      acc_start_i = 1'h1;
      step();
      acc_start_i = 1'h0;
      chk(acc_busy_o | memory_strobe_oe_o, 1'h0);
      {bus_mode_select_i, output_disable_n_i} = 2'h2;
      step(5);
      chk(memory_strobe_oe_o | rw_oe_o, 1'h0);
      output_disable_n_i = 1'h1;
      $display("host test done");
   endtask
   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      step(20);
      reset_n_i = 1'h1;
      step(4);
      t_ready();
      t_host();
      results();
   end
endmodule

// >>> core/ebcs_ctrl.sv
// Purpose: strobe, ready and direction control of the external bus
// Assumes: access requests come from core logic on clk_i
// Notes: pins exposed as in/out/enable triples; strobe as out/enable only
`timescale 1ns/1ps

module ebcs_ctrl
   import ebcs_pkg::*;
#(
   parameter int WS_W = EBCS_WS_W
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic bus_mode_select_i,
   input wire logic output_disable_n_i,
   input wire logic acc_start_i,
   input wire logic acc_write_i,
   input wire logic acc_io_i,
   input wire logic [WS_W-1:0] acc_wait_i,
   output logic acc_busy_o,
   output logic acc_done_o,
   output logic memory_strobe_n_o,
   output logic memory_strobe_oe_o,
   input wire logic ready_i,
   output logic ready_o,
   output logic ready_oe_o,
   input wire logic host_data_ready_i,
   input wire logic rw_i,
   output logic rw_o,
   output logic rw_oe_o,
   output logic host_rw_o,
   input wire logic io_space_select_n_i,
   output logic io_space_select_n_o,
   output logic io_space_select_oe_o,
   input wire logic general_io_b_line3_i,
   input wire logic general_io_b_line3_dir_i,
   input wire logic timer_b_output_i,
   input wire logic timer_b_sel_i,
   output logic general_io_b_line3_o
);
   typedef enum logic [1:0] {ebcs_idle, ebcs_wait, ebcs_ready} ebcs_state_t;

   // any state but idle means an access is open
   function automatic logic ebcs_busy(ebcs_state_t s);
      return s != ebcs_idle;
   endfunction

   // below two wait states ready is never looked at
   function automatic logic ebcs_needs_ready(logic [WS_W-1:0] ws);
      return ws >= WS_W'(EBCS_READY_MIN_WS);
   endfunction

   ebcs_state_t state_r, state_nxt;
   logic [WS_W-1:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt;
   logic io_r, io_nxt;
   logic sample_r, sample_nxt;
   logic done_nxt, busy_nxt, host_rw_nxt;
   logic mode_s1_r, mode_r;
   logic off_s1_r, off_r;
   logic rdy_s1_r, rdy_r;
   logic rw_s1_r, rw_in_r;
   logic gp_s1_r, gp_r;
   logic strb_nxt, strb_oe_nxt;
   logic rdo_nxt, rdo_oe_nxt;
   logic rwo_nxt, rwo_oe_nxt;
   logic iso_nxt, iso_oe_nxt;

   // pins are asynchronous; two flops before use
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mode_s1_r <= 1'b0;
         mode_r <= 1'b0;
         off_s1_r <= 1'b0;
         off_r <= 1'b0;
         rdy_s1_r <= 1'b0;
         rdy_r <= 1'b0;
         rw_s1_r <= 1'b1;
         rw_in_r <= 1'b1;
         gp_s1_r <= 1'b0;
         gp_r <= 1'b0;
      end else begin
         mode_s1_r <= bus_mode_select_i;
         mode_r <= mode_s1_r;
         off_s1_r <= output_disable_n_i;
         off_r <= off_s1_r;
         rdy_s1_r <= ready_i;
         rdy_r <= rdy_s1_r;
         rw_s1_r <= rw_i;
         rw_in_r <= rw_s1_r;
         gp_s1_r <= general_io_b_line3_i;
         gp_r <= gp_s1_r;
      end
   end

   logic ext_mode;
   assign ext_mode = (mode_r == EBCS_MODE_EXTERNAL);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      io_nxt = io_r;
      sample_nxt = sample_r;
      done_nxt = 1'b0;

      case (state_r)
         ebcs_idle: begin
            if (acc_start_i && ext_mode) begin
               wr_nxt = acc_write_i;
               io_nxt = acc_io_i;
               cnt_nxt = acc_wait_i;
               sample_nxt = ebcs_needs_ready(acc_wait_i);
               state_nxt = ebcs_wait;
            end
         end
         ebcs_wait: begin
            // programmed waits run out before ready counts
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end else if (sample_r) begin
               state_nxt = ebcs_ready;
            end else begin
               done_nxt = 1'b1;
               state_nxt = ebcs_idle;
            end
         end
         ebcs_ready: begin
            // retest ready each cycle
            // synced ready lags the pin by two cycles
            if (rdy_r) begin
               done_nxt = 1'b1;
               state_nxt = ebcs_idle;
            end
         end
         default: state_nxt = ebcs_idle;
      endcase
   end

   always_comb begin
      busy_nxt = ebcs_busy(state_nxt);
      strb_nxt = busy_nxt && !io_nxt ? 1'b0 : EBCS_STROBE_IDLE_N;
      strb_oe_nxt = ext_mode && off_r;

      // ready pin reversed in host mode
      rdo_nxt = host_data_ready_i;
      rdo_oe_nxt = !ext_mode && off_r;
      rwo_nxt = (busy_nxt && wr_nxt) ? EBCS_DIR_WRITE : EBCS_DIR_READ;
      // direction pin input in host mode
      rwo_oe_nxt = ext_mode && off_r;
      host_rw_nxt = ext_mode ? 1'b1 : rw_in_r;

      if (ext_mode) begin
         iso_nxt = !(busy_nxt && io_nxt);
         iso_oe_nxt = off_r;
      end else begin
         // general line 3 or timer out
         // pin value synced before it feeds the output
         iso_nxt = timer_b_sel_i ? timer_b_output_i : gp_r;
         iso_oe_nxt = off_r && (timer_b_sel_i || general_io_b_line3_dir_i);
      end
   end

   // all pin outputs registered; cost one cycle latency
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= ebcs_idle;
         cnt_r <= '0;
         wr_r <= 1'b0;
         io_r <= 1'b0;
         sample_r <= 1'b0;
         acc_busy_o <= 1'b0;
         acc_done_o <= 1'b0;
         memory_strobe_n_o <= EBCS_STROBE_IDLE_N;
         memory_strobe_oe_o <= 1'b0;
         ready_o <= 1'b0;
         ready_oe_o <= 1'b0;
         rw_o <= EBCS_DIR_READ;
         rw_oe_o <= 1'b0;
         host_rw_o <= 1'b1;
         io_space_select_n_o <= 1'b1;
         io_space_select_oe_o <= 1'b0;
         general_io_b_line3_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         io_r <= io_nxt;
         sample_r <= sample_nxt;
         acc_busy_o <= busy_nxt;
         acc_done_o <= done_nxt;
         memory_strobe_n_o <= strb_nxt;
         memory_strobe_oe_o <= strb_oe_nxt;
         ready_o <= rdo_nxt;
         ready_oe_o <= rdo_oe_nxt;
         rw_o <= rwo_nxt;
         rw_oe_o <= rwo_oe_nxt;
         host_rw_o <= host_rw_nxt;
         io_space_select_n_o <= iso_nxt;
         io_space_select_oe_o <= iso_oe_nxt;
         general_io_b_line3_o <= gp_r;
      end
   end
endmodule

// >>> core/ebcs_pkg.sv
// Purpose: shared constants for the external bus control block
// Assumes: 100 MHz processor clock
// Notes: wait-state count field is 3 bits wide
package ebcs_pkg;
   localparam int EBCS_WS_W = 3;
   localparam logic [2:0] EBCS_READY_MIN_WS = 3'h2;
   localparam logic EBCS_MODE_EXTERNAL = 1'b1;
   localparam logic EBCS_DIR_READ = 1'b1;
   localparam logic EBCS_DIR_WRITE = 1'b0;
   localparam logic EBCS_STROBE_IDLE_N = 1'b1;
endpackage
